// file: mfp_board.sv
// board model of the shared pins
`timescale 1ns/10ps
module mfp_board (
    // unit pad side
    input wire aclk,
    input wire [31:0] pad_out,
    input wire [31:0] pad_oe,
    input wire [31:0] pad_pull_en,
    input wire [31:0] pad_pull_down,
    // board drivers pulling low
    input wire [31:0] ext_low,
    output wire [31:0] pad_in
);
    reg [31:0] flt_q = 32'h0;
    // a floating pin wanders, so a stale level never reads back
    always @(posedge aclk)
        flt_q <= ~flt_q;
    assign pad_in = pad_oe & pad_out | ~pad_oe & ~ext_low
        & (pad_pull_en & ~pad_pull_down | ~pad_pull_en & flt_q);
endmodule // mfp_board

// file: mfp_chk.sv
// assertions on the pin unit ports
`timescale 1ns/10ps
module mfp_chk #(
    parameter NUM_LINES = 32
)
(
    // clock, reset and bus
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // pins
    input wire [NUM_LINES-1:0] pad_oe,
    input wire [NUM_LINES-1:0] pad_pull_en,
    input wire [NUM_LINES-1:0] pad_pull_down
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_pdn; pad_pull_down == 32'h00c00442; endproperty
    a_pdn: assert property (p_pdn) else $error("pull map");
    property p_poe; (pad_pull_en & pad_oe) == '0; endproperty
    a_poe: assert property (p_poe) else $error("pull on drive");
    property p_rst; $rose(aresetn) |-> pad_pull_en == 32'hfffffc0f; endproperty
    a_rst: assert property (p_rst) else $error("reset pins");
    property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
    a_wr: assert property (p_wr) else $error("no write answer");
    property p_bref; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_bref: assert property (p_bref) else $error("write taken");
    property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("no read answer");
    property p_rref; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_rref: assert property (p_rref) else $error("read taken");
    property p_rclr; $past(s_axi_rvalid && s_axi_rready) |-> !s_axi_rvalid;
    endproperty
    a_rclr: assert property (p_rclr) else $error("read stuck");
    cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
    cover property (pad_oe[31]);
    cover property (s_axi_rvalid && s_axi_rready);
endmodule // mfp_chk

// file: mfpio_regs.vh
// register map, field layout and reset values of the multi-function pin unit
`ifndef MFPIO_REGS_VH
`define MFPIO_REGS_VH
// printed offsets are not all multiples of four: they are indices
`define MFPIO_IDX_MODE_LO 8'h70
`define MFPIO_IDX_DIR_LO 8'h72
`define MFPIO_IDX_LVL_LO 8'h74
`define MFPIO_IDX_MODE_HI 8'h76
`define MFPIO_IDX_DIR_HI 8'h78
`define MFPIO_IDX_LVL_HI 8'h7a
// byte address is four times the index
`define MFPIO_ADDR_W 10
`define MFPIO_ADDR_MODE_LO 10'h1c0
`define MFPIO_ADDR_DIR_LO 10'h1c8
`define MFPIO_ADDR_LVL_LO 10'h1d0
`define MFPIO_ADDR_MODE_HI 10'h1d8
`define MFPIO_ADDR_DIR_HI 10'h1e0
`define MFPIO_ADDR_LVL_HI 10'h1e8
// reset values
`define MFPIO_RST_MODE_LO 16'h0000
`define MFPIO_RST_DIR_LO 16'hfc0f
`define MFPIO_RST_MODE_HI 16'h0000
`define MFPIO_RST_DIR_HI 16'hffff
`define MFPIO_RST_LVL 16'h0000
// pull polarity per line, one means pull-down
`define MFPIO_PULL_DOWN_MAP 32'h00c00442
// axi responses
`define MFPIO_RESP_OKAY 2'b00
`define MFPIO_RESP_SLVERR 2'b10
`endif

// file: mfpio_unit.v
// multi-function programmable line unit with axi4-lite register slave
//
// Behaviour
// (RULE_01) There are thirty-two lines, each sharing a pin with a peripheral.
// (RULE_02) Six registers select per pin between programmable line and peripheral.
// (RULE_03) Mode/direction pairs decode 00 normal, 01 pulled input, 10 output, 11 bare input.
// (RULE_04) Each pin is configured independently of all others.
// (RULE_05) Direction one means input; zero means output or normal per mode bit.
// (RULE_06) Upper level register bits 15..0 map to lines 31..16.
// (RULE_07) Lower level register bits 15..0 map to lines 15..0.
// (RULE_08) An output pin drives its level register bit.
// (RULE_09) Reading an input pin's level bit returns the external pin level.
// (RULE_10) After reset lines 4..9 are normal function, all others pulled inputs.
// (RULE_11) The pull is down on lines 1, 6, 10, 22, 23 and up elsewhere.
// (RULE_12) Bit n of lower/upper mode and direction controls line n / n+16.
// (RULE_13) Normal mode connects the peripheral signal and ignores the level bit.
`timescale 1ns/10ps
`include "mfpio_regs.vh"

module mfpio_unit #(
    parameter NUM_LINES = 32
)
(
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire [`MFPIO_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [`MFPIO_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // peripheral side of each shared pin
    input wire [NUM_LINES-1:0] periph_out,
    input wire [NUM_LINES-1:0] periph_oe,
    output wire [NUM_LINES-1:0] periph_in,
    // pad side
    input wire [NUM_LINES-1:0] pad_in,
    output reg [NUM_LINES-1:0] pad_out,
    output reg [NUM_LINES-1:0] pad_oe,
    output reg [NUM_LINES-1:0] pad_pull_en,
    output reg [NUM_LINES-1:0] pad_pull_down
);

// ----------------------------------------------------------------
// configuration registers
// ----------------------------------------------------------------
reg [15:0] mode_lo_q;
reg [15:0] dir_lo_q;
reg [15:0] lvl_lo_q;
reg [15:0] mode_hi_q;
reg [15:0] dir_hi_q;
reg [15:0] lvl_hi_q;
reg [NUM_LINES-1:0] pad_meta_q;
reg [NUM_LINES-1:0] pad_sync_q;
wire [NUM_LINES-1:0] line_function_mode_bits;
wire [NUM_LINES-1:0] line_direction_bits;
wire [NUM_LINES-1:0] line_level_bits;
wire [NUM_LINES-1:0] pull_down_map;

// (RULE_12) low register bits to lines 0..15
assign line_function_mode_bits = {mode_hi_q, mode_lo_q};
assign line_direction_bits = {dir_hi_q, dir_lo_q};
// (RULE_06) upper word maps to lines 31..16
// (RULE_07) lower word maps to lines 15..0
assign line_level_bits = {lvl_hi_q, lvl_lo_q};
assign pull_down_map = `MFPIO_PULL_DOWN_MAP;

// ----------------------------------------------------------------
// pad input synchroniser
// ----------------------------------------------------------------
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        pad_meta_q <= {NUM_LINES{1'b0}};
        pad_sync_q <= {NUM_LINES{1'b0}};
    end
    else
    begin
        pad_meta_q <= pad_in;
        pad_sync_q <= pad_meta_q;
    end
end

// peripheral sees the pad only in normal mode; a programmable line
// presents a quiet zero so peripherals don't react to gpio traffic
// (RULE_13) peripheral input path
assign periph_in = pad_sync_q & ~line_function_mode_bits
    & ~line_direction_bits;

// ----------------------------------------------------------------
// per-pin decode
// ----------------------------------------------------------------
integer i;
always @*
begin
    pad_out = {NUM_LINES{1'b0}};
    pad_oe = {NUM_LINES{1'b0}};
    pad_pull_en = {NUM_LINES{1'b0}};
    pad_pull_down = {NUM_LINES{1'b0}};
    // (RULE_01) thirty-two shared lines
    // (RULE_04) each pin decoded from its own bit pair only
    for (i = 0; i < NUM_LINES; i = i + 1)
    begin
        // (RULE_11) fixed pull polarity
        pad_pull_down[i] = pull_down_map[i];
        // (RULE_03) mode/direction pair decode
        // (RULE_05) direction one is input
        case ({line_function_mode_bits[i], line_direction_bits[i]})
            2'b00:
            begin
                // (RULE_13) peripheral drives the pin
                pad_out[i] = periph_out[i];
                pad_oe[i] = periph_oe[i];
            end
            2'b01:
            begin
                pad_pull_en[i] = 1'b1;
            end
            2'b10:
            begin
                // (RULE_08) output drives level bit
                pad_out[i] = line_level_bits[i];
                pad_oe[i] = 1'b1;
            end
            default:
            begin
                pad_pull_en[i] = 1'b0;
            end
        endcase
    end
end

// read view: inputs show the pin, others the stored level
// (RULE_09) input lines read the pad
wire [NUM_LINES-1:0] level_view;
assign level_view = (line_level_bits & ~line_direction_bits)
    | (pad_sync_q & line_direction_bits);

// ----------------------------------------------------------------
// axi4-lite write channel
// ----------------------------------------------------------------
reg aw_held_q;
reg w_held_q;
reg [`MFPIO_ADDR_W-1:0] awaddr_q;
reg [15:0] wdata_q;
reg [1:0] wstrb_q;
wire do_write;
wire [15:0] wr_mask;
wire [15:0] wr_val;
reg wr_hit;

// address and data taken independently, then written together
assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
assign wr_mask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
assign wr_val = wdata_q;

always @*
begin
    case (awaddr_q & ~`MFPIO_ADDR_W'h3)
        `MFPIO_ADDR_MODE_LO, `MFPIO_ADDR_DIR_LO, `MFPIO_ADDR_LVL_LO,
        `MFPIO_ADDR_MODE_HI, `MFPIO_ADDR_DIR_HI, `MFPIO_ADDR_LVL_HI:
            wr_hit = 1'b1;
        default:
            wr_hit = 1'b0;
    endcase
end

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        awaddr_q <= {`MFPIO_ADDR_W{1'b0}};
        wdata_q <= 16'h0000;
        wstrb_q <= 2'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `MFPIO_RESP_OKAY;
    end
    else
    begin
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata[15:0];
            wstrb_q <= s_axi_wstrb[1:0];
        end
        if (do_write)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `MFPIO_RESP_OKAY : `MFPIO_RESP_SLVERR;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// register storage
// ----------------------------------------------------------------
// (RULE_10) reset: lines 4..9 normal, others pulled inputs
// (RULE_02) six configuration registers steer the pins
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        mode_lo_q <= `MFPIO_RST_MODE_LO;
        dir_lo_q <= `MFPIO_RST_DIR_LO;
        mode_hi_q <= `MFPIO_RST_MODE_HI;
        dir_hi_q <= `MFPIO_RST_DIR_HI;
        lvl_lo_q <= `MFPIO_RST_LVL;
        lvl_hi_q <= `MFPIO_RST_LVL;
    end
    else if (do_write)
    begin
        case (awaddr_q & ~`MFPIO_ADDR_W'h3)
            `MFPIO_ADDR_MODE_LO:
                mode_lo_q <= (mode_lo_q & ~wr_mask) | (wr_val & wr_mask);
            `MFPIO_ADDR_DIR_LO:
                dir_lo_q <= (dir_lo_q & ~wr_mask) | (wr_val & wr_mask);
            `MFPIO_ADDR_LVL_LO:
                lvl_lo_q <= (lvl_lo_q & ~wr_mask) | (wr_val & wr_mask);
            `MFPIO_ADDR_MODE_HI:
                mode_hi_q <= (mode_hi_q & ~wr_mask) | (wr_val & wr_mask);
            `MFPIO_ADDR_DIR_HI:
                dir_hi_q <= (dir_hi_q & ~wr_mask) | (wr_val & wr_mask);
            `MFPIO_ADDR_LVL_HI:
                lvl_hi_q <= (lvl_hi_q & ~wr_mask) | (wr_val & wr_mask);
            default:
                lvl_hi_q <= lvl_hi_q;
        endcase
    end
end

// ----------------------------------------------------------------
// axi4-lite read channel
// ----------------------------------------------------------------
assign s_axi_arready = ~s_axi_rvalid;

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `MFPIO_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `MFPIO_RESP_OKAY;
        case (s_axi_araddr & ~`MFPIO_ADDR_W'h3)
            `MFPIO_ADDR_MODE_LO:
                s_axi_rdata <= {16'h0000, mode_lo_q};
            `MFPIO_ADDR_DIR_LO:
                s_axi_rdata <= {16'h0000, dir_lo_q};
            `MFPIO_ADDR_LVL_LO:
                s_axi_rdata <= {16'h0000, level_view[15:0]};
            `MFPIO_ADDR_MODE_HI:
                s_axi_rdata <= {16'h0000, mode_hi_q};
            `MFPIO_ADDR_DIR_HI:
                s_axi_rdata <= {16'h0000, dir_hi_q};
            `MFPIO_ADDR_LVL_HI:
                s_axi_rdata <= {16'h0000, level_view[31:16]};
            default:
            begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `MFPIO_RESP_SLVERR;
            end
        endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
        s_axi_rvalid <= 1'b0;
    end
end

endmodule // mfpio_unit

// file: test_multi_function_pin_io_unit.sv
// bench for the pin unit
`timescale 1ns/10ps
module test_multi_function_pin_io_unit;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [9:0] s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h3;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] periph_out = 32'h55aa55aa, periph_oe = 32'hffffffff;
    logic [31:0] ext_low = 32'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata, periph_in, pad_in, pad_out, pad_oe;
    wire [31:0] pad_pull_en, pad_pull_down;
    wire [7:0] low_pins = {pad_oe[2:0], pad_out[0], pad_pull_en[2:0], pad_out[4]};
    integer err_count = 0, total_checks = 0;
    mfpio_unit dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .periph_out(periph_out),
        .periph_oe(periph_oe), .periph_in(periph_in), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pad_pull_en),
        .pad_pull_down(pad_pull_down)
    );
    mfp_board u_board (
        .aclk(aclk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pull_en(pad_pull_en), .pad_pull_down(pad_pull_down),
        .ext_low(ext_low), .pad_in(pad_in)
    );
    initial
    begin
        forever
            #12.5 aclk = ~aclk;
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        begin
            total_checks = total_checks + 1;
            if (s !== e)
            begin
                err_count = err_count + 1;
                $display("mismatch t=%0t seen %h exp %h", $time, s, e);
            end
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", total_checks, err_count);
            if (err_count == 0 && total_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // one bus transfer; write when w is high; response compared, and read data only on reads
    task bus(input logic w, input logic [9:0] a, input logic [15:0] d,
        input logic [1:0] r);
        integer n;
        logic v, ta, tw;
        logic [31:0] q;
        begin
            @(posedge aclk);
            {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, 16'h0, d};
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
            {s_axi_arvalid, s_axi_rready} <= {2{!w}};
            v = 1'b0;
            for (n = 0; n < 20 && !v; n = n + 1)
            begin
                @(negedge aclk);
                v = w ? s_axi_bvalid : s_axi_rvalid;
                ta = w ? s_axi_awready : s_axi_arready;
                tw = s_axi_wready;
                q = w ? {s_axi_bresp, 14'h0, d}
                    : {s_axi_rresp, s_axi_rdata[29:0]};
                @(posedge aclk);
                if (ta)
                    {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
                if (tw)
                    s_axi_wvalid <= 1'b0;
            end
            {s_axi_bready, s_axi_rready} <= 2'b00;
            if (!v)
            begin
                // a hung handshake counts as a mismatch
                err_count = err_count + 1;
                give_verdict;
            end
            else
                chk(q, {r, 14'h0, d});
        end
    endtask
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        bus(0, 10'h1c8, 16'hfc0f, 2'b00);
        bus(0, 10'h1d0, 16'hf80d, 2'b00);
        bus(0, 10'h1e8, 16'hff3f, 2'b00);
        chk(pad_oe & 32'hffff, 32'h3f0);
        chk(pad_out & 32'h3f0, periph_out & 32'h3f0);
        chk(periph_in, periph_out & 32'h3f0);
        $display("reset test done");
        ext_low <= 32'h4;
        bus(1, 10'h1c0, 16'h0005, 2'b00);
        bus(1, 10'h1c8, 16'hfc0e, 2'b00);
        bus(1, 10'h1d0, 16'h0011, 2'b00);
        chk({24'h0, low_pins}, 32'h34);
        bus(0, 10'h1d0, 16'hf819, 2'b00);
        bus(1, 10'h1d8, 16'h8000, 2'b00);
        bus(1, 10'h1e0, 16'h7fff, 2'b00);
        bus(1, 10'h1e8, 16'h7fff, 2'b00);
        chk({pad_oe[31:16], 15'h0, pad_out[31]}, 32'h80000000);
        bus(0, 10'h1e8, 16'h7f3f, 2'b00);
        $display("pin mode test done");
        bus(1, 10'h000, 16'h1234, 2'b10);
        bus(0, 10'h000, 16'h0000, 2'b10);
        $display("unmapped test done");
        give_verdict;
    end
endmodule // test_multi_function_pin_io_unit
bind mfpio_unit mfp_chk #(.NUM_LINES(NUM_LINES)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pad_oe(pad_oe), .pad_pull_en(pad_pull_en),
    .pad_pull_down(pad_pull_down)
);
